// ===== rtl/pxi_cfg.svh
/*
  Constants of the proximity sensor command port: bus address, command codes,
  reset values, field positions and interrupt flag bits.
  Assumes inclusion by bare name from the design module.
*/
`ifndef PXI_CFG_SVH
`define PXI_CFG_SVH

// Fixed 7-bit bus address of the device.
`define PXI_BUS_ADDR 7'h60

// Command codes, each selecting one low/high byte pair.
`define PXI_CMD_CONF1 8'h00
`define PXI_CMD_CONF2 8'h03
`define PXI_CMD_CONF3 8'h04
`define PXI_CMD_THDL 8'h05
`define PXI_CMD_THDH 8'h06
`define PXI_CMD_CANC 8'h07
`define PXI_CMD_CONF4 8'h08
`define PXI_CMD_DATA 8'hF8
`define PXI_CMD_FLAG 8'hF9
`define PXI_CMD_IDENT 8'hFA
`define PXI_CMD_ACDATA 8'hFB

// Index of each writable word in the configuration store.
`define PXI_IDX_CONF1 3'h0
`define PXI_IDX_CONF2 3'h1
`define PXI_IDX_CONF3 3'h2
`define PXI_IDX_THDL 3'h3
`define PXI_IDX_THDH 3'h4
`define PXI_IDX_CANC 3'h5
`define PXI_IDX_CONF4 3'h6
`define PXI_CFG_WORDS 7

// Reset values of the configuration words.
`define PXI_CONF1_RST 16'h0001
`define PXI_CONF2_RST 16'h0001
`define PXI_CONF_RST 16'h0000

// Fields of the period/persistence/interrupt byte.
`define PXI_PERS_MSB 5
`define PXI_PERS_LSB 4
`define PXI_IRQM_MSB 3
`define PXI_IRQM_LSB 2
`define PXI_STOP_BIT 0

// Interrupt flag bits inside the flag byte.
`define PXI_FLAG_AWAY 0
`define PXI_FLAG_CLOSE 1

// Bit count of one byte on the bus.
`define PXI_BYTE_BITS 4'h8

`endif

// ===== rtl/pxi_pkg.sv
/*
  Types of the proximity sensor command port.
  Assumes pxi_cfg.svh holds all numeric constants.
*/
package pxi_pkg;

  // Bus protocol states of the slave.
  typedef enum logic [3:0] {
    PXI_IDLE,
    PXI_ADDR,
    PXI_ADDR_ACK,
    PXI_RX,
    PXI_RX_ACK,
    PXI_TX,
    PXI_TX_ACK,
    PXI_TX_NEXT,
    PXI_IGNORE
  } pxi_state_t;

  // One finished measurement from the sensing logic.
  typedef struct packed {
    logic valid;
    logic [11:0] value;
  } pxi_meas_t;

  // Auto-calibration word with its status bits on top.
  typedef struct packed {
    logic busy;
    logic sun_protect;
    logic [13:0] value;
  } pxi_autocal_t;

endpackage

// ===== rtl/pxi_sensor_port.sv
/*
  Proximity sensor command port: two-wire bus slave with word-wide command
  registers, measurement capture and the threshold interrupt with persistence.
  Assumes the measurement and calibration inputs come from logic on clk, and
  that scl, sda_in arrive asynchronously from pins with external pull-ups.
*/
// How it works
// - Answer only bus address 0x60.
// - Registers move as command plus two bytes.
// - Read: command, restart, low then high byte.
// - Device acks; host acks low, nacks high.
// - Word 0xF8 read returns 12-bit measurement.
// - Reading flag word clears pending interrupt.
// - Interrupt when above high or below low.
// - Interrupt only after persistent consecutive excursions.
// - Word 0x00 resets to low 0x01.
// - Word 0x03 low resets 0x01; others zero.
// - Writable low threshold at 0x05.
// - Writable high threshold at 0x06.
// - Writable crosstalk cancellation at 0x07.
// - Measurement word 0xF8 is read-only.
// - Identification word at 0xFA, read-only.
// - Calibration word 0xFB carries busy, sunlight status.
// - Persistence code selects one to four.
`timescale 1ns/10ps
`include "pxi_cfg.svh"

module pxi_sensor_port #(
  parameter logic [15:0] PART_IDENT = 16'h00A5 // Arbitrary identification value.
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_out,
  output logic int_oe,
  output logic measure_run,
  input wire pxi_pkg::pxi_meas_t meas_in,
  input wire pxi_pkg::pxi_autocal_t autocal_in
);
  import pxi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic start_det, stop_det, scl_rise, scl_fall;
  pxi_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, cmd_reg, lo_reg;
  logic [1:0] rx_idx_reg;
  logic rw_reg, sda_oe_reg, wr_stb_reg, int_oe_reg, run_reg;
  logic [2:0] wr_idx_reg;
  logic [15:0] wr_data_reg, tx_word_reg;
  logic [15:0] cfg_reg [`PXI_CFG_WORDS];
  logic [11:0] meas_reg;
  logic [7:0] flags_reg, flags_next, flag_set;
  logic [2:0] hi_cnt_reg, lo_cnt_reg;
  logic [1:0] pers;
  logic irq_en, above, below, meas_take, word_load, flag_clr;
  logic [3:0] slot;

  // Maps a command code to a writable word; bit 3 flags a valid mapping.
  function automatic logic [3:0] cfg_slot(input logic [7:0] cmd);
    unique case (cmd)
      `PXI_CMD_CONF1: cfg_slot = {1'b1, `PXI_IDX_CONF1};
      `PXI_CMD_CONF2: cfg_slot = {1'b1, `PXI_IDX_CONF2};
      `PXI_CMD_CONF3: cfg_slot = {1'b1, `PXI_IDX_CONF3};
      `PXI_CMD_THDL: cfg_slot = {1'b1, `PXI_IDX_THDL};
      `PXI_CMD_THDH: cfg_slot = {1'b1, `PXI_IDX_THDH};
      `PXI_CMD_CANC: cfg_slot = {1'b1, `PXI_IDX_CANC};
      `PXI_CMD_CONF4: cfg_slot = {1'b1, `PXI_IDX_CONF4};
      default: cfg_slot = 4'h0;
    endcase
  endfunction

  // Reset value of each configuration word.
  function automatic logic [15:0] cfg_reset(input int idx);
    if (idx == int'(`PXI_IDX_CONF1))
    begin
      cfg_reset = `PXI_CONF1_RST;
    end
    else if (idx == int'(`PXI_IDX_CONF2))
    begin
      cfg_reset = `PXI_CONF2_RST;
    end
    else
    begin
      cfg_reset = `PXI_CONF_RST;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk)
  begin
    scl_s1 <= scl;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
  end

  // Bus conditions seen on the synchronised lines.
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;

  // Word loaded for a read; a flag word load clears what it captured.
  assign word_load = (state_reg == PXI_ADDR) & scl_fall & (bit_cnt_reg == `PXI_BYTE_BITS)
    & (shift_reg[7:1] == `PXI_BUS_ADDR) & shift_reg[0];
  assign flag_clr = word_load & (cmd_reg == `PXI_CMD_FLAG);

  // Writable word addressed by the held command code; bit 3 marks a mapped code.
  assign slot = cfg_slot(cmd_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address match, command and data bytes, acknowledge, send.
  always_ff @(posedge clk)
  begin
    wr_stb_reg <= 1'b0;
    if (sys_rst)
    begin
      state_reg <= PXI_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      lo_reg <= 8'h00;
      rx_idx_reg <= 2'h0;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      tx_word_reg <= 16'h0000;
      wr_idx_reg <= 3'h0;
      wr_data_reg <= 16'h0000;
    end
    else if (start_det)
    begin
      state_reg <= PXI_ADDR;
      bit_cnt_reg <= 4'h0;
      rx_idx_reg <= 2'h0;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= PXI_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        PXI_ADDR:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == `PXI_BYTE_BITS)
          begin
            if (shift_reg[7:1] == `PXI_BUS_ADDR)
            begin
              sda_oe_reg <= 1'b1;
              rw_reg <= shift_reg[0];
              state_reg <= PXI_ADDR_ACK;
              if (shift_reg[0])
              begin
                unique case (cmd_reg)
                  `PXI_CMD_DATA: tx_word_reg <= {4'h0, meas_reg};
                  `PXI_CMD_FLAG: tx_word_reg <= {flags_reg, 8'h00};
                  `PXI_CMD_IDENT: tx_word_reg <= PART_IDENT;
                  `PXI_CMD_ACDATA: tx_word_reg <= autocal_in;
                  default: tx_word_reg <= slot[3] ? cfg_reg[slot[2:0]] : 16'h0000;
                endcase
              end
            end
            else
            begin
              state_reg <= PXI_IGNORE;
            end
          end
        end
        PXI_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_reg)
            begin
              state_reg <= PXI_TX;
              sda_oe_reg <= ~tx_word_reg[7];
              shift_reg <= {tx_word_reg[6:0], 1'b0};
              bit_cnt_reg <= 4'h1;
            end
            else
            begin
              state_reg <= PXI_RX;
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
        end
        PXI_RX:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == `PXI_BYTE_BITS)
          begin
            if (rx_idx_reg != 2'h3)
            begin
              sda_oe_reg <= 1'b1;
              state_reg <= PXI_RX_ACK;
              if (rx_idx_reg == 2'h0)
              begin
                cmd_reg <= shift_reg;
              end
              else if (rx_idx_reg == 2'h1)
              begin
                lo_reg <= shift_reg;
              end
              else
              begin
                wr_stb_reg <= slot[3];
                wr_idx_reg <= slot[2:0];
                wr_data_reg <= {shift_reg, lo_reg};
              end
            end
            else
            begin
              state_reg <= PXI_IGNORE;
            end
          end
        end
        PXI_RX_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_reg <= 1'b0;
            state_reg <= PXI_RX;
            bit_cnt_reg <= 4'h0;
            rx_idx_reg <= rx_idx_reg + 2'h1;
          end
        end
        PXI_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_reg == `PXI_BYTE_BITS)
            begin
              sda_oe_reg <= 1'b0;
              state_reg <= PXI_TX_ACK;
            end
            else
            begin
              sda_oe_reg <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        PXI_TX_ACK:
        begin
          if (scl_rise)
          begin
            state_reg <= sda_s2 ? PXI_IGNORE : PXI_TX_NEXT;
          end
        end
        PXI_TX_NEXT:
        begin
          if (scl_fall)
          begin
            state_reg <= PXI_TX;
            sda_oe_reg <= ~tx_word_reg[15];
            shift_reg <= {tx_word_reg[14:8], 1'b0};
            bit_cnt_reg <= 4'h1;
          end
        end
        PXI_IDLE, PXI_IGNORE:
        begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration store, one writable word per entry.
  generate
    for (genvar i = 0; i < `PXI_CFG_WORDS; i++)
    begin : g_cfg
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          cfg_reg[i] <= cfg_reset(i);
        end
        else if (wr_stb_reg && wr_idx_reg == 3'(i))
        begin
          cfg_reg[i] <= wr_data_reg;
        end
      end
    end
  endgenerate

  // Configuration fields that steer the measurement and interrupt logic.
  assign pers = cfg_reg[`PXI_IDX_CONF2][`PXI_PERS_MSB:`PXI_PERS_LSB];
  assign irq_en = |cfg_reg[`PXI_IDX_CONF2][`PXI_IRQM_MSB:`PXI_IRQM_LSB];
  assign meas_take = meas_in.valid & ~cfg_reg[`PXI_IDX_CONF2][`PXI_STOP_BIT];
  assign above = {4'h0, meas_in.value} > cfg_reg[`PXI_IDX_THDH];
  assign below = {4'h0, meas_in.value} < cfg_reg[`PXI_IDX_THDL];

  ////////////////////////////////////////////////////////////////////////////
  // Measurement capture and consecutive excursion counters.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meas_reg <= 12'h000;
      hi_cnt_reg <= 3'h0;
      lo_cnt_reg <= 3'h0;
    end
    else if (meas_take)
    begin
      meas_reg <= meas_in.value;
      hi_cnt_reg <= above ? ((hi_cnt_reg == 3'h3) ? 3'h3 : hi_cnt_reg + 3'h1) : 3'h0;
      lo_cnt_reg <= below ? ((lo_cnt_reg == 3'h3) ? 3'h3 : lo_cnt_reg + 3'h1) : 3'h0;
    end
  end

  // A run of pers+1 excursions sets a flag; a set beats a read clear.
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`PXI_FLAG_CLOSE] = meas_take & irq_en & above & ({1'b0, pers} <= hi_cnt_reg);
    flag_set[`PXI_FLAG_AWAY] = meas_take & irq_en & below & ({1'b0, pers} <= lo_cnt_reg);
    flags_next = (flag_clr ? 8'h00 : flags_reg) | flag_set;
  end

  // Flag byte and open-drain interrupt pin.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flags_reg <= 8'h00;
      int_oe_reg <= 1'b0;
      run_reg <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      int_oe_reg <= |flags_next;
      run_reg <= ~cfg_reg[`PXI_IDX_CONF2][`PXI_STOP_BIT];
    end
  end

  // Pins drive low only; the enables carry the level.
  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0;
    int_out <= 1'b0;
  end

  assign sda_oe = sda_oe_reg;
  assign int_oe = int_oe_reg;
  assign measure_run = run_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  foreign_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == PXI_ADDR) && scl_fall && !start_det && !stop_det && bit_cnt_reg == `PXI_BYTE_BITS
    && shift_reg[7:1] != `PXI_BUS_ADDR |=> (state_reg == PXI_IGNORE) && !sda_oe_reg)
    else $error("Foreign address was not ignored.");

  data_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == PXI_RX) && scl_fall && !start_det && !stop_det && bit_cnt_reg == `PXI_BYTE_BITS
    && rx_idx_reg != 2'h3 |=> sda_oe_reg && (state_reg == PXI_RX_ACK))
    else $error("Received byte was not acknowledged.");

  high_byte_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == PXI_TX_NEXT) && scl_fall && !start_det && !stop_det
    |=> (sda_oe_reg == ~$past(tx_word_reg[15])) && (bit_cnt_reg == 4'h1))
    else $error("High byte did not follow the low byte.");

  flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    flag_clr && flag_set == 8'h00 |=> flags_reg == 8'h00 ##1 !int_oe_reg)
    else $error("Flag read did not clear the interrupt.");

  irq_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    flags_reg != 8'h00 |-> int_oe_reg)
    else $error("Interrupt pin released while a flag is pending.");

  persist_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(flags_reg[`PXI_FLAG_CLOSE]) |-> $past(hi_cnt_reg) >= {1'b0, $past(pers)} && $past(above))
    else $error("Interrupt set before the persistence count.");

  reset_cfg_a: assert property (@(posedge clk)
    $past(sys_rst) |-> cfg_reg[0] == `PXI_CONF1_RST && cfg_reg[1] == `PXI_CONF2_RST
    && cfg_reg[3] == `PXI_CONF_RST)
    else $error("Configuration reset values wrong.");

  ro_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == PXI_RX) && scl_fall && !start_det && !stop_det && bit_cnt_reg == `PXI_BYTE_BITS
    && rx_idx_reg == 2'h2 && !slot[3] |=> !wr_stb_reg ##1 $stable(cfg_reg[4]))
    else $error("Write to a read-only word took effect.");

  meas_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
    meas_take |=> meas_reg == $past(meas_in.value))
    else $error("Measurement not captured.");

  thr_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_stb_reg && wr_idx_reg == `PXI_IDX_THDH |=> cfg_reg[`PXI_IDX_THDH] == $past(wr_data_reg))
    else $error("High threshold write lost.");

endmodule

// ===== testbench/proximity_i2c_register_interrupt_test.sv
/*
  Self-checking bench of the proximity sensor command port: a word model of
  the registers and interrupt flags is compared with every read and the pin.
  Assumes the host model in pxi_host_model.sv and pull-ups on both pins.
*/
`timescale 1ns/10ps

module proximity_i2c_register_interrupt_test;
  import pxi_pkg::*;
  localparam logic [15:0] IDENT = 16'h5A3C; // Arbitrary identification value.
  localparam int LIMIT = 60000;
  logic clk, sys_rst, scl, sda, sda_pull, sda_out, sda_oe, int_out, int_oe, measure_run, int_pin;
  pxi_meas_t meas_in;
  pxi_autocal_t autocal_in;
  int n_errors, comparisons, cycles, run_hi, run_lo;
  int mdl [int];

  // Open-drain pins with pull-ups: a released line reads high.
  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  assign int_pin = int_oe ? int_out : 1'b1;

  pxi_sensor_port #(.PART_IDENT(IDENT)) i_pxi_sensor_port (.clk(clk), .sys_rst(sys_rst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
    .measure_run(measure_run), .meas_in(meas_in), .autocal_in(autocal_in));
  pxi_host_model i_pxi_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  ////////////////////////////////////////////////////////////
  // Free-running clock of 10 ns.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_errors++;
      test_done;
    end
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Word write; only writable words take the data in the model.
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [3:0] nak;
    i_pxi_host_model.write_word(7'h60, c, d, nak);
    check("write acks", 16'(nak), 16'h0000);
    if (c inside {8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08})
      mdl[c] = d;
  endtask

  // Word read against the model; a flag read clears flags and the pin.
  task automatic rd(input logic [7:0] c);
    logic [15:0] d;
    logic [2:0] nak;
    i_pxi_host_model.read_word(7'h60, c, d, nak);
    check("read acks", 16'(nak), 16'h0000);
    check("read word", d, mdl.exists(c) ? 16'(mdl[c]) : 16'h0000);
    if (c == 8'hF9)
    begin
      mdl[c] = 0;
      check("released interrupt", 16'(int_pin), 16'h0001);
    end
  endtask

  // One measurement pulse, then the flag model and the interrupt pin.
  task automatic meas(input int v);
    int pers;
    @(posedge clk);
    #1;
    meas_in = '{1'b1, v[11:0]};
    @(posedge clk);
    #1;
    meas_in.valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    pers = (mdl[8'h03] >> 4) & 3;
    mdl[8'hF8] = v;
    run_hi = (v > mdl[8'h06]) ? run_hi + 1 : 0;
    run_lo = (v < mdl[8'h05]) ? run_lo + 1 : 0;
    if (run_hi > pers)
      mdl[8'hF9] = mdl[8'hF9] | 16'h0200;
    if (run_lo > pers)
      mdl[8'hF9] = mdl[8'hF9] | 16'h0100;
    check("interrupt pin", 16'(int_pin), 16'(mdl[8'hF9] == 0));
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [3:0] nak;
    sys_rst = 1'b1;
    meas_in = '0;
    void'($urandom(45764));
    autocal_in = pxi_autocal_t'($urandom);
    mdl = '{'h00: 1, 'h03: 1, 'h04: 0, 'h05: 0, 'h06: 0, 'h07: 0, 'h08: 0, 'hF8: 0, 'hF9: 0};
    mdl[8'hFA] = IDENT;
    mdl[8'hFB] = autocal_in;
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    foreach (mdl[c])
      rd(8'(c));
    wr(8'h01, 16'h00FF);
    rd(8'h01);
    for (int c = 5; c < 8; c++)
    begin
      wr(8'(c), 16'($urandom));
      rd(8'(c));
    end
    for (int c = 'hF8; c < 'hFC; c++)
    begin
      wr(8'(c), 16'($urandom));
      rd(8'(c));
    end
    i_pxi_host_model.write_word(7'h21, 8'h05, 16'h1234, nak);
    check("foreign address acks", 16'(nak), 16'h000F);
    rd(8'h05);
    // Reserved fields stay at defaults; only the window, persistence, interrupt mode and run bits move.
    wr(8'h05, 16'h0064);
    wr(8'h06, 16'h0BB8);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h03, 16'(p * 16 + 12));
      check("measure run", 16'(measure_run), 16'h0001);
      meas(p[0] ? 100 : 3000);
      for (int k = 0; k <= p; k++)
        meas(p[0] ? $urandom_range(99, 0) : $urandom_range(4095, 3001));
      rd(8'hF8);
      rd(8'hF9);
    end
    test_done;
  end
endmodule

// ===== testbench/pxi_host_model.sv
/*
  Host model of the two-wire bus: drives the clock line and pulls the data line
  low, for word writes and word reads.
  Assumes the bench resolves the data line with a pull-up and feeds it back.
*/
`timescale 1ns/10ps

module pxi_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  ////////////////////////////////////////////////////////////
  // Both lines start released, as the pull-ups leave them.
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Waits n clocks and steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond;
    sda_pull = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_pull = 1'b1;
    tick(10);
    scl = 1'b0;
    tick(5);
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop_cond;
    sda_pull = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_pull = 1'b0;
    tick(10);
  endtask

  // One bit: data set mid-low, sampled mid-high, low and high ten clocks each.
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    tick(5);
    scl = 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl = 1'b0;
    tick(5);
  endtask

  // One byte, most significant bit first, then the acknowledge bit.
  task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_tx, ack_rx);
  endtask

  ////////////////////////////////////////////////////////////
  // Word write; nak holds the four acknowledge bits, low means acked.
  task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d,
    output logic [3:0] nak);
    logic [7:0] rx;
    start_cond;
    byte_io({adr, 1'b0}, 1'b1, rx, nak[3]);
    byte_io(cmd, 1'b1, rx, nak[2]);
    byte_io(d[7:0], 1'b1, rx, nak[1]);
    byte_io(d[15:8], 1'b1, rx, nak[0]);
    stop_cond;
  endtask

  // Word read: command, repeated start, low byte acked, high byte not acked.
  task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd, output logic [15:0] d,
    output logic [2:0] nak);
    logic [7:0] rx;
    logic ign;
    start_cond;
    byte_io({adr, 1'b0}, 1'b1, rx, nak[2]);
    byte_io(cmd, 1'b1, rx, nak[1]);
    start_cond;
    byte_io({adr, 1'b1}, 1'b1, rx, nak[0]);
    byte_io(8'hFF, 1'b0, d[7:0], ign);
    byte_io(8'hFF, 1'b1, d[15:8], ign);
    stop_cond;
  endtask
endmodule
